// File: logic/cio_buffer.sv
// Two-entry image buffer between sensor readout and packet transmission.
// Assumes one clock; full and empty are exact.
`timescale 1ns/1ps
module cio_buffer (
   // Clock and reset
   input wire logic   clk,
   input wire logic   resetn,
   // Streams
   cio_stream_if.snk  in_s,
   cio_stream_if.src  out_s
);
   import cio_pkg::*;

   logic [WORD_BITS:0] mem_q [2];
   logic               wr_ptr_q;
   logic               rd_ptr_q;
   logic [1:0]         count_q;
   logic               push;
   logic               pop;

   assign in_s.ready  = (count_q != 2'h2);
   assign out_s.valid = (count_q != 2'h0);
   assign out_s.data  = mem_q[rd_ptr_q][WORD_BITS-1:0];
   assign out_s.last  = mem_q[rd_ptr_q][WORD_BITS];
   assign push        = in_s.valid && in_s.ready;
   assign pop         = out_s.valid && out_s.ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_ptr_q] <= {in_s.last, in_s.data};
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         count_q  <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr_q <= ~wr_ptr_q;
         end
         if (pop) begin
            rd_ptr_q <= ~rd_ptr_q;
         end
         if (push && !pop) begin
            count_q <= count_q + 2'h1;
         end else if (pop && !push) begin
            count_q <= count_q - 2'h1;
         end
      end
   end
endmodule

// File: logic/cio_pwr_pulse.sv
// Power-on pulse: low for a delay, high for a fixed time, then low for good.
// Assumes reset is released once at power on.
`timescale 1ns/1ps
module cio_pwr_pulse #(
   parameter int unsigned DELAY_CYC = 20000000,
   parameter int unsigned HIGH_CYC  = 75000000
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic resetn,
   // Pulse
   output logic      pulse_q
);
   import cio_pkg::*;

   logic [31:0] cnt_q;
   logic        done_q;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         cnt_q   <= 32'h0;
         pulse_q <= 1'b0;
         done_q  <= 1'b0;
      end else if (!done_q) begin
         cnt_q <= cnt_q + 32'h1;
         if (!pulse_q && cnt_q == DELAY_CYC - 1) begin
            pulse_q <= 1'b1;
            cnt_q   <= 32'h0;
         end else if (pulse_q && cnt_q == HIGH_CYC - 1) begin
            pulse_q <= 1'b0;
            done_q  <= 1'b1;
         end
      end
   end
endmodule

// File: logic/cio_top.sv
// Camera digital I/O, exposure sequencing and readout toward the packet link.
// Assumes input pins are asynchronous; digitizer and link run on clk.
//
// Overview of operation
// - Trigger taken from input 0 after reset.
// - Output 0 shows exposure active by default.
// - Output 1 shows trigger ready by default.
// - Software may reroute signals to outputs.
// - Outputs 0 and 2 low after power on; output 1 high (idle).
// - Output 3 pulses high after power on.
// - Logic one turns output transistor on.
// - Rising trigger starts fixed-length exposure.
// - Readout starts when exposure time ends.
// - Pixels digitized to twelve bits.
// - Readout runs line by line to frame end.
// - Buffer decouples readout from transmission.
// - Image data sent as packets to host.
// - Transmit rate capped at 400 Mbit/s.
// - Shot commands start exposure without trigger.
`timescale 1ns/1ps
module cio_top #(
   parameter int unsigned PWR_DELAY_CYCLES = cio_pkg::PWR_DELAY_CYC,
   parameter int unsigned PWR_HIGH_CYCLES  = cio_pkg::PWR_HIGH_CYC
) (
   // Clock and reset
   input  wire logic                                       clk,
   input  wire logic                                       resetn,
   // Input pins
   input  wire logic [cio_pkg::NUM_IN-1:0]                 in_port,
   // Output pins, one drives the output transistor on
   output logic      [cio_pkg::NUM_OUT-1:0]                out_port,
   // Configuration, loaded on cfg_load
   input  wire logic                                       cfg_load,
   input  wire logic [1:0]                                 trig_port_sel,
   input  wire logic [cio_pkg::NUM_OUT*cio_pkg::SEL_BITS-1:0] out_route,
   input  wire logic [cio_pkg::EXP_BITS-1:0]               exposure_value,
   // Start control
   input  wire logic                                       trig_enable,
   input  wire logic                                       one_shot,
   input  wire logic                                       continuous_shot,
   // Sensor digitizer
   input  wire logic [cio_pkg::PIX_BITS-1:0]               adc_data,
   output logic                                            pixel_shift,
   output logic                                            line_shift,
   // Packet link
   output logic      [cio_pkg::WORD_BITS-1:0]              pkt_data,
   output logic                                            pkt_valid,
   output logic                                            pkt_start,
   output logic                                            pkt_end,
   input  wire logic                                       pkt_ready,
   // Status
   output logic                                            one_shot_pending
);
   import cio_pkg::*;

   localparam int PIXW = $clog2(LINE_PIXELS);
   localparam int LINW = $clog2(FRAME_LINES);
   localparam int TBW  = $clog2(EXP_BASE_CYC);
   localparam int PDW  = $clog2(PIX_DIV);
   localparam int TXW  = $clog2(TX_WORD_CYC + 1);
   localparam int PKW  = $clog2(PKT_WORDS);

   // Pick one internal signal by its routing code
   function automatic logic sig_pick(input logic [SEL_BITS-1:0] sel,
                                     input logic [3:0]          sigs);
      logic r;
      r = 1'b0;
      unique case (cio_sig_t'(sel))
         CIO_SIG_EXPOSE:    r = sigs[0];
         CIO_SIG_TRIG_RDY:  r = sigs[1];
         CIO_SIG_READOUT:   r = sigs[2];
         CIO_SIG_PWR_PULSE: r = sigs[3];
         CIO_SIG_LOW:       r = 1'b0;
         CIO_SIG_HIGH:      r = 1'b1;
         default:           r = 1'b0;
      endcase
      return r;
   endfunction

   cio_stream_if rd_s ();
   cio_stream_if tx_s ();

   logic [NUM_IN-1:0]           sync1_q;
   logic [NUM_IN-1:0]           sync2_q;
   logic                        trig_lvl_q;
   logic [1:0]                  trig_sel_q;
   logic [NUM_OUT*SEL_BITS-1:0] route_q;
   logic [EXP_BITS-1:0]         exp_value_q;
   cio_state_t                  state_q;
   logic [TBW-1:0]              tb_cnt_q;
   logic [EXP_BITS-1:0]         exp_units_q;
   logic [PDW-1:0]              pix_div_q;
   logic [PIXW-1:0]             pix_q;
   logic [LINW-1:0]             line_q;
   logic [TXW-1:0]              tx_cnt_q;
   logic [PKW-1:0]              pkt_idx_q;
   logic [NUM_OUT-1:0]          out_port_q;
   logic [WORD_BITS-1:0]        pkt_data_q;
   logic                        pkt_valid_q;
   logic                        pkt_start_q;
   logic                        pkt_end_q;
   logic                        pixel_shift_q;
   logic                        line_shift_q;
   logic                        one_shot_q;
   logic                        pwr_pulse;
   logic                        trig_rise;
   logic                        start_exp;
   logic                        tb_tick;
   logic                        exp_done;
   logic                        pix_tick;
   logic                        pix_step;
   logic                        line_end;
   logic                        frame_end;
   logic                        tx_take;
   logic [EXP_BITS-1:0]         exp_target;
   logic [3:0]                  sig_vec;

   // Two-stage synchronisers on every input pin
   always_ff @(posedge clk) begin
      if (!resetn) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= in_port;
         sync2_q <= sync1_q;
      end
   end

   // Configuration holding, defaults after reset
   always_ff @(posedge clk) begin
      if (!resetn) begin
         trig_sel_q  <= TRIG_PORT_RST;
         route_q     <= OUT_ROUTE_RST;
         exp_value_q <= EXP_VALUE_RST;
      end else if (cfg_load) begin
         trig_sel_q  <= trig_port_sel;
         route_q     <= out_route;
         exp_value_q <= exposure_value;
      end
   end

   // Edge detection only looks at the second stage
   always_ff @(posedge clk) begin
      if (!resetn) begin
         trig_lvl_q <= 1'b0;
      end else begin
         trig_lvl_q <= sync2_q[trig_sel_q];
      end
   end

   assign trig_rise = sync2_q[trig_sel_q] && !trig_lvl_q;

   // One-shot request waits for the sequencer; a new request wins over its clear
   always_ff @(posedge clk) begin
      if (!resetn) begin
         one_shot_q <= 1'b0;
      end else if (one_shot) begin
         one_shot_q <= 1'b1;
      end else if (start_exp && !trig_enable) begin
         one_shot_q <= 1'b0;
      end
   end

   // Start source: external trigger when enabled, else shot commands
   always_comb begin
      start_exp = 1'b0;
      if (state_q == CIO_IDLE) begin
         if (trig_enable) begin
            start_exp = trig_rise;
         end else begin
            start_exp = one_shot_q || continuous_shot;
         end
      end
   end

   // Exposure time base: one enable pulse every EXP_BASE_CYC cycles
   assign tb_tick    = (tb_cnt_q == TBW'(EXP_BASE_CYC - 1));
   assign exp_target = (exp_value_q == '0) ? EXP_BITS'(1) : exp_value_q;
   assign exp_done   = tb_tick && (exp_units_q == exp_target - EXP_BITS'(1));

   always_ff @(posedge clk) begin
      if (!resetn || state_q != CIO_EXPOSE) begin
         tb_cnt_q    <= '0;
         exp_units_q <= '0;
      end else if (tb_tick) begin
         tb_cnt_q    <= '0;
         exp_units_q <= exp_units_q + EXP_BITS'(1);
      end else begin
         tb_cnt_q <= tb_cnt_q + TBW'(1);
      end
   end

   // Readout pacing: one pixel per PIX_DIV cycles, held while the buffer is full
   assign pix_tick  = (pix_div_q == PDW'(PIX_DIV - 1));
   assign pix_step  = (state_q == CIO_READOUT) && pix_tick && rd_s.ready;
   assign line_end  = (pix_q == PIXW'(LINE_PIXELS - 1));
   assign frame_end = line_end && (line_q == LINW'(FRAME_LINES - 1));

   always_ff @(posedge clk) begin
      if (!resetn || state_q != CIO_READOUT) begin
         pix_div_q <= '0;
      end else if (!pix_tick || rd_s.ready) begin
         pix_div_q <= pix_div_q + PDW'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn || state_q != CIO_READOUT) begin
         pix_q  <= '0;
         line_q <= '0;
      end else if (pix_step) begin
         if (line_end) begin
            pix_q  <= '0;
            line_q <= line_q + LINW'(1);
         end else begin
            pix_q <= pix_q + PIXW'(1);
         end
      end
   end

   // Sequencer
   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_q <= CIO_IDLE;
      end else begin
         unique case (state_q)
            CIO_IDLE: begin
               if (start_exp) begin
                  state_q <= CIO_EXPOSE;
               end
            end
            CIO_EXPOSE: begin
               if (exp_done) begin
                  state_q <= CIO_READOUT;
               end
            end
            CIO_READOUT: begin
               if (pix_step && frame_end) begin
                  state_q <= CIO_IDLE;
               end
            end
         endcase
      end
   end

   // Sensor shift strobes
   always_ff @(posedge clk) begin
      if (!resetn) begin
         pixel_shift_q <= 1'b0;
         line_shift_q  <= 1'b0;
      end else begin
         pixel_shift_q <= pix_step;
         line_shift_q  <= pix_step && line_end && !frame_end;
      end
   end

   // Digitized pixel into the buffer, zero-extended to a link word
   assign rd_s.data  = {{(WORD_BITS - PIX_BITS){1'b0}}, adc_data};
   assign rd_s.last  = frame_end;
   assign rd_s.valid = pix_step;

   cio_buffer u_buffer (
      .clk    (clk),
      .resetn (resetn),
      .in_s   (rd_s.snk),
      .out_s  (tx_s.src)
   );

   // Link pacing: link handshakes stay TX_WORD_CYC cycles apart, even after a stall
   assign tx_take    = tx_s.valid && tx_s.ready;
   assign tx_s.ready = (tx_cnt_q == '0) && !pkt_valid_q;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         tx_cnt_q <= '0;
      end else if (pkt_valid_q && pkt_ready) begin
         tx_cnt_q <= TXW'(TX_WORD_CYC - 2);
      end else if (tx_cnt_q != '0) begin
         tx_cnt_q <= tx_cnt_q - TXW'(1);
      end
   end

   // Packet framing: PKT_WORDS words per packet, frame end closes a packet early
   always_ff @(posedge clk) begin
      if (!resetn) begin
         pkt_data_q  <= '0;
         pkt_valid_q <= 1'b0;
         pkt_start_q <= 1'b0;
         pkt_end_q   <= 1'b0;
         pkt_idx_q   <= '0;
      end else if (tx_take) begin
         pkt_data_q  <= tx_s.data;
         pkt_valid_q <= 1'b1;
         pkt_start_q <= (pkt_idx_q == '0);
         pkt_end_q   <= tx_s.last || (pkt_idx_q == PKW'(PKT_WORDS - 1));
         if (tx_s.last || pkt_idx_q == PKW'(PKT_WORDS - 1)) begin
            pkt_idx_q <= '0;
         end else begin
            pkt_idx_q <= pkt_idx_q + PKW'(1);
         end
      end else if (pkt_ready) begin
         pkt_valid_q <= 1'b0;
         pkt_start_q <= 1'b0;
         pkt_end_q   <= 1'b0;
      end
   end

   cio_pwr_pulse #(
      .DELAY_CYC (PWR_DELAY_CYCLES),
      .HIGH_CYC  (PWR_HIGH_CYCLES)
   ) u_pwr_pulse (
      .clk     (clk),
      .resetn  (resetn),
      .pulse_q (pwr_pulse)
   );

   // Internal signals available to the output router
   assign sig_vec = {pwr_pulse,
                     state_q == CIO_READOUT,
                     state_q == CIO_IDLE,
                     state_q == CIO_EXPOSE};

   // Output router, one registered port each; all ports low in reset
   for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
      always_ff @(posedge clk) begin
         if (!resetn) begin
            out_port_q[i] <= 1'b0;
         end else begin
            out_port_q[i] <= sig_pick(route_q[i*SEL_BITS +: SEL_BITS], sig_vec);
         end
      end
   end

   assign out_port         = out_port_q;
   assign pkt_data         = pkt_data_q;
   assign pkt_valid        = pkt_valid_q;
   assign pkt_start        = pkt_start_q;
   assign pkt_end          = pkt_end_q;
   assign pixel_shift      = pixel_shift_q;
   assign line_shift       = line_shift_q;
   assign one_shot_pending = one_shot_q;
endmodule

// File: shared/cio_pkg.sv
// Constants and types shared by the camera I/O trigger and readout block.
// Assumes a single 100 MHz clock; every time figure is converted to cycles here.
package cio_pkg;
   localparam int CLK_MHZ    = 100;
   localparam int NUM_IN     = 4;
   localparam int NUM_OUT    = 4;
   localparam int PIX_BITS   = 12;
   localparam int WORD_BITS  = 16;
   localparam int SEL_BITS   = 3;
   localparam int EXP_BITS   = 12;

   // Exposure time base, one unit of the exposure value
   localparam int EXP_BASE_US  = 20;
   localparam int EXP_BASE_CYC = EXP_BASE_US * CLK_MHZ;

   // Power-on pulse on output port 3
   localparam int PWR_DELAY_MS  = 200;
   localparam int PWR_HIGH_MS   = 750;
   localparam int PWR_DELAY_CYC = PWR_DELAY_MS * 1000 * CLK_MHZ;
   localparam int PWR_HIGH_CYC  = PWR_HIGH_MS * 1000 * CLK_MHZ;

   // Link rate ceiling: least spacing between words, rounded up
   localparam int TX_MBPS     = 400;
   localparam int TX_WORD_CYC = (WORD_BITS * CLK_MHZ + TX_MBPS - 1) / TX_MBPS;

   // Sensor readout pace and geometry, and words per link packet
   localparam int PIX_DIV     = 8;
   localparam int LINE_PIXELS = 640;
   localparam int FRAME_LINES = 480;
   localparam int PKT_WORDS   = 256;

   // Internal signals that can be routed to an output port
   typedef enum logic [SEL_BITS-1:0] {
      CIO_SIG_EXPOSE,
      CIO_SIG_TRIG_RDY,
      CIO_SIG_READOUT,
      CIO_SIG_PWR_PULSE,
      CIO_SIG_LOW,
      CIO_SIG_HIGH
   } cio_sig_t;

   localparam logic [1:0] TRIG_PORT_RST = 2'h0;
   localparam logic [NUM_OUT*SEL_BITS-1:0] OUT_ROUTE_RST =
      {CIO_SIG_PWR_PULSE, CIO_SIG_LOW, CIO_SIG_TRIG_RDY, CIO_SIG_EXPOSE};
   localparam logic [EXP_BITS-1:0] EXP_VALUE_RST = 12'h064;

   typedef enum logic [1:0] {CIO_IDLE, CIO_EXPOSE, CIO_READOUT} cio_state_t;
endpackage

// File: shared/cio_stream_if.sv
// Word stream with valid/ready between the readout, buffer and packet stages.
// Assumes all parties run on one clock.
`timescale 1ns/1ps
interface cio_stream_if;
   logic [cio_pkg::WORD_BITS-1:0] data;
   logic                          last;
   logic                          valid;
   logic                          ready;
   modport src (output data, output last, output valid, input ready);
   modport snk (input data, input last, input valid, output ready);
endinterface

// File: sim/cio_host_model.sv
// Host side of the packet link: accepts words at full rate, half rate or not at all.
// Assumes the bench chooses the pace; ready changes at the falling edge only.
`timescale 1ns/1ps
module cio_host_model (
   // Clock and reset
   input  wire logic clk,
   input  wire logic resetn,
   // Pace control
   input  wire logic stall,
   input  wire logic slow,
   // Link
   output logic      pkt_ready
);
   logic toggle_q;

   initial begin
      pkt_ready = 1'b0;
      toggle_q  = 1'b0;
   end

   // Half rate alternates ready so words wait with valid high
   always @(negedge clk) begin
      toggle_q  <= ~toggle_q;
      pkt_ready <= resetn && !stall && (!slow || toggle_q);
   end
endmodule

// File: sim/cio_top_chk.sv
// Port checks for the camera I/O trigger and readout top module.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module cio_top_chk (
   // Clock and reset
   input wire logic                         clk,
   input wire logic                         resetn,
   // Watched ports
   input wire logic [cio_pkg::NUM_OUT-1:0]  out_port,
   input wire logic                         pixel_shift,
   input wire logic                         line_shift,
   input wire logic [cio_pkg::WORD_BITS-1:0] pkt_data,
   input wire logic                         pkt_valid,
   input wire logic                         pkt_start,
   input wire logic                         pkt_end,
   input wire logic                         pkt_ready,
   input wire logic                         one_shot_pending
);
   import cio_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   rst_outs_a: assert property ($rose(resetn) |-> out_port == 4'h0)
      else $error("outputs not low after reset");
   rst_link_a: assert property ($rose(resetn)
      |-> !pkt_valid && !pixel_shift && !line_shift && !one_shot_pending)
      else $error("link or readout active after reset");
   pkt_hold_a: assert property (pkt_valid && !pkt_ready
      |=> pkt_valid && $stable(pkt_data) && $stable(pkt_start) && $stable(pkt_end))
      else $error("link word changed while stalled");
   pkt_rate_a: assert property (pkt_valid && pkt_ready
      |=> (!(pkt_valid && pkt_ready))[*3])
      else $error("link words closer than four cycles");
   pix_width_a: assert property (pkt_valid |-> pkt_data[15:12] == 4'h0)
      else $error("pixel wider than twelve bits");
   pixel_pace_a: assert property (pixel_shift |=> (!pixel_shift)[*7])
      else $error("pixel steps closer than eight cycles");
   line_pace_a: assert property (line_shift |=> (!line_shift)[*8])
      else $error("line steps too close");
   frame_mark_a: assert property (pkt_start || pkt_end |-> pkt_valid)
      else $error("packet mark without word");

   cover property (pkt_valid && !pkt_ready);
   cover property (line_shift);
   cover property (pkt_start && pkt_valid && pkt_ready);
endmodule

bind cio_top cio_top_chk u_chk (.clk(clk), .resetn(resetn), .out_port(out_port),
   .pixel_shift(pixel_shift), .line_shift(line_shift), .pkt_data(pkt_data),
   .pkt_valid(pkt_valid), .pkt_start(pkt_start), .pkt_end(pkt_end),
   .pkt_ready(pkt_ready), .one_shot_pending(one_shot_pending));

// File: sim/cio_top_tb_top.sv
// Self-checking bench for the camera I/O top: trigger, exposure, routing, readout, link.
// Assumes the host model paces the link and the bench acts as digitizer and trigger source.
`timescale 1ns/1ps
module cio_top_tb_top;
   import cio_pkg::*;
   localparam int PWR_DLY = 20;
   localparam int PWR_HI  = 30;

   logic        clk = 1'b0;
   logic        resetn, cfg_load, trig_enable, one_shot, continuous_shot, stall, slow;
   logic [3:0]  in_port;
   logic [1:0]  trig_port_sel;
   logic [11:0] out_route, exposure_value, adc_data;
   logic [3:0]  out_port;
   logic [15:0] pkt_data, exp_w;
   logic        pixel_shift, line_shift, pkt_valid, pkt_start, pkt_end, pkt_ready;
   logic        one_shot_pending;
   logic [15:0] q[$];
   logic [31:0] seed = 32'h17;
   int          errors = 0, compares = 0, widx = 0, pix_n = 0, line_n = 0;
   int          i, j, n, lat, rise, high;

   always #5 clk = ~clk;

   cio_top #(.PWR_DELAY_CYCLES(PWR_DLY), .PWR_HIGH_CYCLES(PWR_HI)) dut (.clk(clk),
      .resetn(resetn), .in_port(in_port), .out_port(out_port), .cfg_load(cfg_load),
      .trig_port_sel(trig_port_sel), .out_route(out_route), .exposure_value(exposure_value),
      .trig_enable(trig_enable), .one_shot(one_shot), .continuous_shot(continuous_shot),
      .adc_data(adc_data), .pixel_shift(pixel_shift), .line_shift(line_shift),
      .pkt_data(pkt_data), .pkt_valid(pkt_valid), .pkt_start(pkt_start), .pkt_end(pkt_end),
      .pkt_ready(pkt_ready), .one_shot_pending(one_shot_pending));
   cio_host_model host (.clk(clk), .resetn(resetn), .stall(stall), .slow(slow),
      .pkt_ready(pkt_ready));

   function automatic logic [11:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[11:0];
   endfunction

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic conclude();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic do_reset();
      resetn = 1'b0;
      repeat (7) @(negedge clk);
      check("reset outs", 16'(out_port), 16'h0);
      @(negedge clk);
      resetn = 1'b1;
      q.delete();
      widx = 0;
      pix_n = 0;
   endtask

   task automatic load(input logic [11:0] route);
      out_route = route;
      cfg_load = 1'b1;
      @(negedge clk);
      cfg_load = 1'b0;
   endtask

   // Digitizer: note each pixel taken, then offer a fresh value
   always @(negedge clk) begin
      if (resetn && pixel_shift === 1'b1) begin
         q.push_back({4'h0, adc_data});
         adc_data <= rnd();
      end
   end

   // Link and readout monitor
   always @(posedge clk) begin
      if (resetn && pkt_valid === 1'b1 && pkt_ready === 1'b1) begin
         exp_w = (q.size() > 0) ? q.pop_front() : 16'hFFFF;
         check("pkt_data", pkt_data, exp_w);
         check("pkt_start", 16'(pkt_start), 16'(widx % PKT_WORDS == 0));
         check("pkt_end", 16'(pkt_end), 16'(widx % PKT_WORDS == PKT_WORDS - 1));
         widx++;
      end
      if (resetn && pixel_shift === 1'b1) pix_n++;
      if (resetn && line_shift === 1'b1) begin
         line_n++;
         check("line length", 16'(pix_n % LINE_PIXELS), 16'h0);
      end
   end

   initial begin
      #400000;
      errors++;
      conclude();
   end

   initial begin
      in_port = 4'h0;
      cfg_load = 1'b0;
      trig_port_sel = TRIG_PORT_RST;
      out_route = OUT_ROUTE_RST;
      exposure_value = 12'h001;
      trig_enable = 1'b1;
      one_shot = 1'b0;
      continuous_shot = 1'b0;
      adc_data = 12'h000;
      stall = 1'b0;
      slow = 1'b0;
      resetn = 1'b0;
      do_reset();
      rise = 0;
      high = 0;
      for (i = 0; i < 80; i++) begin
         @(negedge clk);
         if (out_port[3] === 1'b1) begin
            if (high == 0) rise = i;
            high++;
         end
         if (i == 10) check("idle outs", 16'(out_port[2:0]), 16'h2);
      end
      check("pulse rise", 16'(rise >= PWR_DLY - 2 && rise <= PWR_DLY + 3), 16'h1);
      check("pulse width", 16'(high), 16'(PWR_HI));
      load(OUT_ROUTE_RST);
      for (i = 1; i < 4; i++) begin
         in_port[i] = 1'b1;
         repeat (5) @(negedge clk);
         in_port[i] = 1'b0;
      end
      repeat (10) @(negedge clk);
      check("other pins", 16'(out_port[0]), 16'h0);
      in_port[0] = 1'b1;
      lat = 0;
      while (lat < 9 && out_port[0] !== 1'b1) begin
         @(negedge clk);
         lat++;
         if (lat == 2) in_port[0] = 1'b0;
      end
      check("start delay", 16'(lat >= 3 && lat <= 5), 16'h1);
      check("start outs", 16'(out_port[1:0]), 16'h1);
      n = 0;
      for (j = 0; j < 3000; j++) begin
         if (out_port[0] !== 1'b1) break;
         n++;
         in_port[0] = (j >= 100 && j < 110);
         @(negedge clk);
      end
      check("exposure length", 16'(n), 16'(EXP_BASE_CYC));
      for (j = 0; j < 40 && pixel_shift !== 1'b1; j++) @(negedge clk);
      check("readout start", 16'(j < 40), 16'h1);
      for (i = 4; i < 8; i++) begin
         load({CIO_SIG_READOUT, 3'(i), CIO_SIG_TRIG_RDY, CIO_SIG_EXPOSE});
         repeat (3) @(negedge clk);
         check("routed", 16'(out_port[3:1]), {13'h0, 1'b1, i == 5, 1'b0});
      end
      slow = 1'b1;
      repeat (200) @(negedge clk);
      slow = 1'b0;
      stall = 1'b1;
      n = 0;
      for (j = 0; j < 100; j++) begin
         @(negedge clk);
         if (j >= 60 && pixel_shift === 1'b1) n++;
      end
      check("stalled pace", 16'(n), 16'h0);
      stall = 1'b0;
      for (j = 0; j < 9000 && pix_n < 700; j++) @(negedge clk);
      check("words sent", 16'(widx >= 300 && line_n > 0), 16'h1);
      for (i = 0; i < 2; i++) begin
         do_reset();
         trig_enable = 1'b0;
         load(OUT_ROUTE_RST);
         if (i == 0) begin
            one_shot = 1'b1;
            @(negedge clk);
            one_shot = 1'b0;
            check("shot pending", 16'(one_shot_pending), 16'h1);
         end else begin
            continuous_shot = 1'b1;
         end
         for (j = 0; j < 20 && out_port[0] !== 1'b1; j++) @(negedge clk);
         check("shot start", 16'(j < 20), 16'h1);
         check("shot clear", 16'(one_shot_pending), 16'h0);
      end
      do_reset();
      trig_enable = 1'b1;
      continuous_shot = 1'b0;
      trig_port_sel = 2'h2;
      load(OUT_ROUTE_RST);
      in_port[0] = 1'b1;
      repeat (8) @(negedge clk);
      check("unselected pin", 16'(out_port[0]), 16'h0);
      in_port[2] = 1'b1;
      for (j = 0; j < 10 && out_port[0] !== 1'b1; j++) @(negedge clk);
      check("selected pin", 16'(j), 16'h4);
      conclude();
   end
endmodule
